// File: rtl/shp_pkg.sv
// Purpose: Shared constants for the SRAM-like host bus port.
// Assumes: Core clock of 250 MHz (4 ns period).
// Notes: Address is the word address bits [7:1] of the host bus.
package shp_pkg;
    localparam int unsigned CLK_PERIOD_PS = 4000;
    localparam int unsigned T_CSH_MIN_PS = 13000;
    localparam int unsigned T_CYCLE_MIN_PS = 165000;
    localparam int unsigned T_CSDV_MAX_PS = 30000;
    // Least times round up, longest times round down.
    localparam int unsigned CSH_CYC = (T_CSH_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned CYCLE_CYC = (T_CYCLE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned CSDV_CYC = T_CSDV_MAX_PS / CLK_PERIOD_PS;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned FIFO_DEPTH = 16;
    localparam int unsigned BURST_MAX = 16;
    // Word addresses (A[7:1]) of the reachable resources.
    localparam logic [6:0] ADDR_RXD_LO = 7'h00;
    localparam logic [6:0] ADDR_RXD_HI = 7'h03;
    localparam logic [6:0] ADDR_RXSTS = 7'h20;
    localparam logic [6:0] ADDR_TXSTS = 7'h24;
    localparam logic [6:0] ADDR_FREE_RUN = 7'h4e;
    localparam logic [6:0] ADDR_CTRL = 7'h50;
    localparam logic [6:0] ADDR_STATUS = 7'h51;
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] IDLE_DATA = 16'h0000;
    localparam logic [1:0] FIFO_IDX_MASK = 2'h3;
endpackage : shp_pkg

// File: rtl/shp_fifo.sv
// Purpose: Parameterised synchronous FIFO with valid/ready on both sides.
// Assumes: One clock, synchronous active-low reset.
// Notes: Depth must be a power of two.
`timescale 1ns/10ps
module shp_fifo #(
    parameter int unsigned WIDTH = 16,
    parameter int unsigned DEPTH = 16
) (
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic [WIDTH-1:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [WIDTH-1:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_ff;
    logic [AW:0] rd_ptr_ff;
    logic push;
    logic pop;
    logic [AW:0] nxt_wr_ptr;
    logic [AW:0] nxt_rd_ptr;
    logic in_ready_ff;

    // Extra pointer bit tells full from empty honestly.
    assign out_valid_o = (wr_ptr_ff != rd_ptr_ff);
    // Ready comes from a flop so that it can leave the block with no logic behind it.
    assign in_ready_o = in_ready_ff;
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem[rd_ptr_ff[AW-1:0]];
    assign nxt_wr_ptr = wr_ptr_ff + {{AW{1'b0}}, push};
    assign nxt_rd_ptr = rd_ptr_ff + {{AW{1'b0}}, pop};

    // Storage write.
    always_ff @(posedge ref_clk_i) begin
        if (push) begin
            mem[wr_ptr_ff[AW-1:0]] <= in_data_i;
        end
    end

    // Pointer update.
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            in_ready_ff <= 1'b1;
        end else begin
            wr_ptr_ff <= nxt_wr_ptr;
            rd_ptr_ff <= nxt_rd_ptr;
            in_ready_ff <= (nxt_wr_ptr[AW-1:0] != nxt_rd_ptr[AW-1:0]) ||
                           (nxt_wr_ptr[AW] == nxt_rd_ptr[AW]);
        end
    end
endmodule : shp_fifo

// File: rtl/shp_host_port.sv
// Purpose: Device side of an SRAM-like 16-bit host bus port with a receive data FIFO.
// Assumes: Host strobes are asynchronous to ref_clk_i and are synchronised here.
// Notes: Host-side timing (spacing, strobe widths) is the host's duty and is not policed.
`timescale 1ns/10ps
module shp_host_port
    import shp_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic chip_select_n_i,
    input wire logic read_strobe_n_i,
    input wire logic write_strobe_n_i,
    input wire logic fifo_sel_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] data_i,
    output logic [DATA_W-1:0] data_o,
    output logic data_oe_o,
    input wire logic [DATA_W-1:0] rx_data_i,
    input wire logic rx_valid_i,
    output logic rx_ready_o,
    input wire logic [DATA_W-1:0] rx_status_i,
    input wire logic [DATA_W-1:0] tx_status_i,
    output logic [DATA_W-1:0] ctrl_o
);
    typedef enum logic [1:0] {
        SHP_IDLE = 2'b00,
        SHP_READ = 2'b01,
        SHP_WRITE = 2'b10
    } shp_state_e;

    // Decodes a direct receive-FIFO access from address and select.
    function automatic logic is_fifo_addr(input logic sel, input logic [ADDR_W-1:0] a);
        is_fifo_addr = sel || (a >= ADDR_RXD_LO && a <= ADDR_RXD_HI);
    endfunction : is_fifo_addr

    ////////////////////////////////////////////////////////////////////////////
    // Three-stage synchronisers; a change counts once stages two and three agree.
    localparam int unsigned NSYNC = 4 + ADDR_W + DATA_W;
    logic [NSYNC-1:0] pin_raw;
    logic [NSYNC-1:0] s1_ff;
    logic [NSYNC-1:0] s2_ff;
    logic [NSYNC-1:0] s3_ff;
    logic [NSYNC-1:0] filt_ff;
    assign pin_raw = {chip_select_n_i, read_strobe_n_i, write_strobe_n_i, fifo_sel_i, addr_i,
                      data_i};

    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            // Filtered level only moves when the last two stages agree.
            always_ff @(posedge ref_clk_i) begin
                if (!reset_n_i) begin
                    s1_ff[gi] <= 1'b1;
                    s2_ff[gi] <= 1'b1;
                    s3_ff[gi] <= 1'b1;
                    filt_ff[gi] <= 1'b1;
                end else begin
                    s1_ff[gi] <= pin_raw[gi];
                    s2_ff[gi] <= s1_ff[gi];
                    s3_ff[gi] <= s2_ff[gi];
                    if (s2_ff[gi] == s3_ff[gi]) begin
                        filt_ff[gi] <= s3_ff[gi];
                    end
                end
            end
        end
    endgenerate

    logic cs_n;
    logic rd_n;
    logic wr_n;
    logic fsel;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdat;
    assign {cs_n, rd_n, wr_n, fsel, addr, wdat} = filt_ff;

    logic rd_act;
    logic wr_act;
    assign rd_act = !cs_n && !rd_n;
    assign wr_act = !cs_n && !wr_n;

    ////////////////////////////////////////////////////////////////////////////
    // Receive data FIFO in the data path.
    logic [DATA_W-1:0] q_data;
    logic q_valid;
    logic q_pop;
    shp_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(FIFO_DEPTH)
    ) u_rx_fifo (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .in_data_i(rx_data_i),
        .in_valid_i(rx_valid_i),
        .in_ready_o(rx_ready_o),
        .out_data_o(q_data),
        .out_valid_o(q_valid),
        .out_ready_i(q_pop)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Cycle state, free-running counter and control register.
    shp_state_e state_ff;
    logic [ADDR_W-1:0] last_addr_ff;
    logic [DATA_W-1:0] free_run_ff;
    logic [DATA_W-1:0] snap_ff;
    logic [DATA_W-1:0] ctrl_ff;
    logic [DATA_W-1:0] wr_data_ff;
    logic [4:0] burst_cnt_ff;
    logic rd_start;
    logic rd_step;

    assign rd_start = (state_ff == SHP_IDLE) && rd_act;
    // Direct FIFO bursts step on the two low word-address bits; the upper bits are ignored.
    assign rd_step = (state_ff == SHP_READ) && rd_act &&
                     (fsel ? (((addr[1:0] ^ last_addr_ff[1:0]) & FIFO_IDX_MASK) != 2'h0)
                           : (addr != last_addr_ff));
    // Each word read pops one FIFO entry; direct-select bursts have no word limit.
    assign q_pop = (rd_start || rd_step) && is_fifo_addr(fsel, addr) && q_valid;

    // Read and write cycle tracking.
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            state_ff <= SHP_IDLE;
            last_addr_ff <= '0;
            burst_cnt_ff <= '0;
        end else begin
            unique case (state_ff)
                SHP_IDLE: begin
                    if (rd_act) begin
                        state_ff <= SHP_READ;
                        burst_cnt_ff <= 5'h01;
                    end else if (wr_act) begin
                        state_ff <= SHP_WRITE;
                    end
                    last_addr_ff <= addr;
                end
                SHP_READ: begin
                    if (!rd_act) begin
                        state_ff <= SHP_IDLE;
                    end else if (rd_step) begin
                        last_addr_ff <= addr;
                        if (burst_cnt_ff != 5'(BURST_MAX)) begin
                            burst_cnt_ff <= burst_cnt_ff + 5'h01;
                        end
                    end
                end
                SHP_WRITE: begin
                    if (!wr_act) begin
                        state_ff <= SHP_IDLE;
                    end
                end
                default: state_ff <= SHP_IDLE;
            endcase
        end
    end

    // Free-running counter, snapped at read start so the host sees a stable value.
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            free_run_ff <= '0;
            snap_ff <= '0;
        end else begin
            free_run_ff <= free_run_ff + 16'h0001;
            if (rd_start) begin
                snap_ff <= free_run_ff;
            end
        end
    end

    // Write data is sampled on every clock while the strobes are low and kept after, since the host may drop it with the strobe.
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            wr_data_ff <= '0;
        end else if (wr_act) begin
            wr_data_ff <= wdat;
        end
    end

    // Control register takes the held word once the write cycle has ended.
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            ctrl_ff <= CTRL_RST;
        end else if (state_ff == SHP_WRITE && !wr_act && last_addr_ff == ADDR_CTRL) begin
            ctrl_ff <= wr_data_ff;
        end
    end
    assign ctrl_o = ctrl_ff;

    // Read mux; fifo select overrides upper address bits.
    logic [DATA_W-1:0] nxt_data;
    always_comb begin
        nxt_data = IDLE_DATA;
        if (is_fifo_addr(fsel, addr)) begin
            nxt_data = q_data;
        end else begin
            unique case (addr)
                ADDR_RXSTS: nxt_data = rx_status_i;
                ADDR_TXSTS: nxt_data = tx_status_i;
                ADDR_FREE_RUN: nxt_data = snap_ff;
                ADDR_CTRL: nxt_data = ctrl_ff;
                ADDR_STATUS: nxt_data = {9'h000, q_valid, burst_cnt_ff, 1'b0};
                default: nxt_data = IDLE_DATA;
            endcase
        end
    end

    // Data is captured at each word start and driven only during a read.
    always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
            data_o <= IDLE_DATA;
            data_oe_o <= 1'b0;
        end else begin
            data_oe_o <= rd_act;
            if (rd_start || rd_step) begin
                data_o <= nxt_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.
    sequence s_read_begin;
        (state_ff == SHP_IDLE) && rd_act;
    endsequence

    AST_OE_ON_READ: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        s_read_begin |=> data_oe_o)
        else $error("data bus not driven after read start");
    AST_OE_OFF: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        !rd_act |=> !data_oe_o)
        else $error("data bus driven outside read");
    AST_READ_END: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (state_ff == SHP_READ) && !rd_act |=> state_ff == SHP_IDLE)
        else $error("read cycle not ended");
    AST_WRITE_BEGIN: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (state_ff == SHP_IDLE) && !rd_act && wr_act |=> state_ff == SHP_WRITE)
        else $error("write cycle not started");
    AST_SNAP: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        s_read_begin |=> snap_ff == $past(free_run_ff))
        else $error("counter not captured at read start");
    AST_SNAP_STABLE: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (state_ff == SHP_READ) && rd_act && !rd_step |=> $stable(snap_ff))
        else $error("captured counter moved during read");
    AST_FIFO_DATA: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        (s_read_begin and fsel) |=> data_o == $past(q_data))
        else $error("fifo select read did not return fifo data");
    AST_FIFO_POP: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
        rd_step && fsel && q_valid |-> q_pop)
        else $error("fifo not popped on address step");
endmodule : shp_host_port

// File: sim/shp_host_model.sv
// Purpose: Host bus master model that drives the SRAM-like port from the far side.
// Assumes: Drives on falling edges of ref_clk_i; one word lasts CYCLE_CYC clocks.
// Notes: Released address, data and select lines show the inverse of their last value.
`timescale 1ns/10ps
module shp_host_model
    import shp_pkg::*;
(
    input wire logic ref_clk_i,
    output logic chip_select_n_o,
    output logic read_strobe_n_o,
    output logic write_strobe_n_o,
    output logic fifo_sel_o,
    output logic [ADDR_W-1:0] addr_o,
    output logic [DATA_W-1:0] data_o,
    input wire logic [DATA_W-1:0] data_i,
    input wire logic data_oe_i
);
    logic [DATA_W-1:0] words[$];
    logic oe_bad;
    logic unstable;

    // Idle bus: no cycle is framed until a task asks for one.
    initial begin
        chip_select_n_o = 1'b1;
        read_strobe_n_o = 1'b1;
        write_strobe_n_o = 1'b1;
        fifo_sel_o = 1'b0;
        addr_o = '0;
        data_o = '0;
        oe_bad = 1'b0;
        unstable = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One access of n words with strobes held low; the address is xor-stepped per word.
    task automatic run(input logic rd, input logic fs, input logic [ADDR_W-1:0] a0,
                       input logic [ADDR_W-1:0] astep, input int n,
                       input logic [DATA_W-1:0] wd);
        logic [DATA_W-1:0] early;
        words.delete();
        @(negedge ref_clk_i);
        fifo_sel_o = fs;
        addr_o = a0;
        data_o = wd;
        chip_select_n_o = 1'b0;
        read_strobe_n_o = !rd;
        write_strobe_n_o = rd;
        for (int k = 0; k < n; k++) begin
            if (k > 0) begin
                addr_o = addr_o ^ astep;
            end
            repeat (10) @(negedge ref_clk_i);
            early = data_i;
            repeat (CYCLE_CYC - 10) @(negedge ref_clk_i);
            if (rd) begin
                // A counter snapshot must not move while the word is on the bus.
                if (early !== data_i) unstable = 1'b1;
                if (data_oe_i !== 1'b1) oe_bad = 1'b1;
                words.push_back(data_i);
            end
        end
        chip_select_n_o = 1'b1;
        read_strobe_n_o = 1'b1;
        write_strobe_n_o = 1'b1;
        addr_o = ~addr_o;
        data_o = ~data_o;
        fifo_sel_o = ~fifo_sel_o;
        repeat (8) @(negedge ref_clk_i);
        if (data_oe_i !== 1'b0) oe_bad = 1'b1;
        // Slowest read-after-write spacing is kept after every write.
        if (!rd) repeat (2 * CYCLE_CYC) @(negedge ref_clk_i);
    endtask : run
endmodule : shp_host_model

// File: sim/sram_like_host_bus_port_bench.sv
// Purpose: Self-checking bench for the host port with its receive FIFO.
// Assumes: Inputs change on falling edges; reset held for 10 clocks.
// Notes: Receive words are numbered from 16'hc000 so order faults show.
`timescale 1ns/10ps
module sram_like_host_bus_port_bench;
    import shp_pkg::*;
    logic ref_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic cs_n, rd_n, wr_n, fsel;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata;
    logic oe, rx_ready_o;
    logic [DATA_W-1:0] rx_data_i = '0;
    logic rx_valid_i = 1'b0;
    logic [DATA_W-1:0] ctrl_o;
    int error_cnt = 0;
    int checks_done = 0;
    int next_push = 0;

    // Clock of 250 MHz.
    always #2 ref_clk_i = ~ref_clk_i;

    shp_host_port dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .chip_select_n_i(cs_n),
        .read_strobe_n_i(rd_n), .write_strobe_n_i(wr_n), .fifo_sel_i(fsel), .addr_i(addr),
        .data_i(wdata), .data_o(rdata), .data_oe_o(oe), .rx_data_i(rx_data_i),
        .rx_valid_i(rx_valid_i), .rx_ready_o(rx_ready_o), .rx_status_i(16'h1234),
        .tx_status_i(16'h8765), .ctrl_o(ctrl_o));

    shp_host_model host (.ref_clk_i(ref_clk_i), .chip_select_n_o(cs_n), .read_strobe_n_o(rd_n),
        .write_strobe_n_o(wr_n), .fifo_sel_o(fsel), .addr_o(addr), .data_o(wdata),
        .data_i(rdata), .data_oe_i(oe));

    ////////////////////////////////////////////////////////////////////////////////
    // Compare one value and count it.
    task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic report_and_stop();
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop

    // Push cnt numbered words whenever the FIFO has room, within a bounded wait.
    task automatic fill(input int cnt);
        int got;
        got = 0;
        for (int c = 0; c < 2000 && got < cnt; c++) begin
            @(negedge ref_clk_i);
            if (rx_ready_o === 1'b1) begin
                rx_data_i = 16'hc000 + next_push[15:0];
                rx_valid_i = 1'b1;
                next_push++;
                got++;
            end else begin
                rx_valid_i = 1'b0;
                rx_data_i = ~rx_data_i;
            end
        end
        @(negedge ref_clk_i);
        rx_valid_i = 1'b0;
        rx_data_i = ~rx_data_i;
        chk(got[15:0], cnt[15:0]);
        if (got < cnt) report_and_stop();
    endtask : fill

    ////////////////////////////////////////////////////////////////////////////////
    // Control write, ignored write, register burst, unmapped read and counter snapshot.
    task automatic t_regs();
        host.run(1'b0, 1'b0, ADDR_CTRL, 7'h00, 1, 16'h5a3c);
        chk(ctrl_o, 16'h5a3c);
        host.run(1'b0, 1'b0, ADDR_STATUS, 7'h00, 1, 16'hffff);
        chk(ctrl_o, 16'h5a3c);
        host.run(1'b1, 1'b0, ADDR_RXSTS, 7'h04, 3, 16'h0000);
        chk(host.words[0], 16'h1234);
        chk(host.words[1], 16'h8765);
        chk(host.words[2], 16'h1234);
        host.run(1'b1, 1'b0, 7'h10, 7'h00, 1, 16'h0000);
        chk(host.words[0], 16'h0000);
        host.run(1'b1, 1'b0, ADDR_FREE_RUN, 7'h00, 1, 16'h0000);
        chk({15'h0, host.unstable}, 16'h0000);
        host.run(1'b1, 1'b0, ADDR_CTRL, 7'h00, 1, 16'h0000);
        chk(host.words[0], 16'h5a3c);
        // Status shows an empty FIFO and the one-word count of the read before it.
        host.run(1'b1, 1'b0, ADDR_STATUS, 7'h00, 1, 16'h0000);
        chk(host.words[0], 16'h0002);
    endtask : t_regs

    // Fill until refused, then direct reads and an over-long burst while refilling.
    task automatic t_fifo();
        fill(16);
        repeat (4) @(negedge ref_clk_i);
        chk({15'h0, rx_ready_o}, 16'h0000);
        host.run(1'b1, 1'b1, 7'h7b, 7'h00, 1, 16'h0000);
        chk(host.words[0], 16'hc000);
        fork
            fill(6);
        join_none
        host.run(1'b1, 1'b1, 7'h78, 7'h7f, 21, 16'h0000);
        for (int k = 0; k < 21; k++) begin
            chk(host.words[k], 16'hc001 + k[15:0]);
        end
        chk({15'h0, rx_ready_o}, 16'h0001);
        chk({15'h0, host.oe_bad}, 16'h0000);
    endtask : t_fifo

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        repeat (10) @(negedge ref_clk_i);
        reset_n_i = 1'b1;
        @(negedge ref_clk_i);
        chk({15'h0, oe}, 16'h0000);
        chk({15'h0, rx_ready_o}, 16'h0001);
        chk(ctrl_o, CTRL_RST);
        t_regs();
        t_fifo();
        report_and_stop();
    end
endmodule : sram_like_host_bus_port_bench
